// >>> rtl/cacr_pkg.sv
// Package with offsets, field positions, reset values and timing counts for the card config block.
package cacr_pkg;
  localparam int CACR_ADDR_W = 11;
  localparam logic [10:0] CACR_OFS_OPTION = 11'h200;
  localparam logic [10:0] CACR_OFS_STATUS = 11'h202;
  localparam logic [10:0] CACR_OFS_PINREP = 11'h204;
  localparam logic [10:0] CACR_OFS_SOCKET = 11'h206;
  localparam int CACR_OPT_SRST = 7;
  localparam int CACR_OPT_LEVEL = 6;
  localparam int CACR_STS_CHANGED = 7;
  localparam int CACR_STS_CHANGE_SIGNAL_ENABLE = 6;
  localparam int CACR_STS_EIGHT = 5;
  localparam int CACR_STS_PWRDN = 2;
  localparam int CACR_STS_INT = 1;
  localparam int CACR_PIN_RDYCHG = 5;
  localparam int CACR_PIN_WPCHG = 4;
  localparam int CACR_PIN_RDYMASK = 1;
  localparam int CACR_PIN_WPMASK = 0;
  localparam logic [7:0] CACR_OPT_RESET = 8'h00;
  localparam logic [7:0] CACR_STS_RESET = 8'h00;
  localparam logic [7:0] CACR_PIN_FIXED = 8'h0c;
  localparam logic [5:0] CACR_IDX_MEMORY = 6'h00;
  localparam logic [5:0] CACR_IDX_IO_ANY = 6'h01;
  localparam logic [5:0] CACR_IDX_IO_PRI = 6'h02;
  localparam logic [5:0] CACR_IDX_IO_SEC = 6'h03;
  localparam int CACR_CLK_MHZ = 50;
  localparam int CACR_PWR_SETTLE_NS = 1000;
  localparam int CACR_PWR_SETTLE_CYC = (CACR_PWR_SETTLE_NS * CACR_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    CACR_SP_STANDBY,
    CACR_SP_COMMON,
    CACR_SP_ATTR,
    CACR_SP_INVALID
  } cacr_space_t;
endpackage : cacr_pkg

// >>> rtl/cacr_sync.sv
// Two flip-flop synchroniser for one bit.
`timescale 1ns/100ps
module cacr_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta_r;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : cacr_sync

// >>> rtl/cacr_regs.sv
// Card bus space decoder with the option, status and pin replacement registers.
`timescale 1ns/100ps
module cacr_regs
  import cacr_pkg::*;
#(
  parameter int SETTLE_CYC = CACR_PWR_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic low_byte_select_n,
  input wire logic high_byte_select_n,
  input wire logic attr_space_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_lo_oe_n,
  output logic data_hi_oe_n,
  output logic [7:0] common_rd_data,
  output logic [15:0] common_wr_data,
  output logic common_wr_pulse,
  output logic common_rd_active,
  output logic [1:0] common_lanes,
  output logic [7:0] table_rd_addr,
  input wire logic [7:0] table_rd_data,
  input wire logic internal_ready,
  input wire logic internal_irq,
  input wire logic irq_disable_ctl,
  input wire logic card_idle,
  input wire logic command_arrived,
  output logic card_reset,
  output logic cmd_hard_reset,
  output logic level_irq_mode,
  output logic [5:0] config_index,
  output logic io_any_mode,
  output logic io_primary_mode,
  output logic io_secondary_mode,
  output logic status_change_out_n,
  output logic ready_busy,
  output logic low_power
);
  logic lbs_s, hbs_s, attr_s, rd_s, wr_s;
  logic [7:0] option_r;
  logic change_signal_enable_r, eight_r, pwrdn_r;
  logic rdy_chg_r, wp_chg_r, rdy_prev_r;
  logic wr_prev_r;
  logic low_power_r, target_lp_r;
  logic [15:0] settle_r;
  logic [7:0] rd_byte, wdat;
  logic [7:0] common_rd_data_hi;
  logic attr_dec, cfg_dec, attr_valid, wr_edge, cfg_wr, changed;
  cacr_space_t space;

  // The busy window must last at least two cycles and fit the 16-bit settle counter.
  if (SETTLE_CYC < 2 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  // Strobes come from the card pins, so every one is synchronised first.
  cacr_sync u_s0 (.clk(clk), .arst_n(arst_n), .d(~low_byte_select_n), .q(lbs_s));
  cacr_sync u_s1 (.clk(clk), .arst_n(arst_n), .d(~high_byte_select_n), .q(hbs_s));
  cacr_sync u_s2 (.clk(clk), .arst_n(arst_n), .d(~attr_space_select_n), .q(attr_s));
  cacr_sync u_s3 (.clk(clk), .arst_n(arst_n), .d(~read_strobe_n), .q(rd_s));
  cacr_sync u_s4 (.clk(clk), .arst_n(arst_n), .d(~write_strobe_n), .q(wr_s));
  // The synchronised copies carry an _s suffix and are active high.

  // Space decode; only the low byte select with A0 low is a legal attribute access.
  always_comb begin
    attr_valid = attr_s && lbs_s && !addr[0];
    if (!lbs_s && !hbs_s) begin
      space = CACR_SP_STANDBY;
    end else if (!attr_s) begin
      space = CACR_SP_COMMON;
    end else if (attr_valid) begin
      space = CACR_SP_ATTR;
    end else begin
      space = CACR_SP_INVALID;
    end
  end

  assign attr_dec = (space == CACR_SP_ATTR);
  assign cfg_dec = attr_dec && !addr[10] && addr[9] && (addr[8:4] == 5'h00) && !addr[3];
  assign wr_edge = wr_s && !wr_prev_r && !rd_s;
  // A table region write (A9 low) never reaches a register.
  assign cfg_wr = wr_edge && cfg_dec;
  assign wdat = data_in[7:0];
  assign changed = rdy_chg_r || wp_chg_r;
  assign table_rd_addr = addr[8:1];

  // Write strobe and ready history for edge detection.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev_r <= 1'b0;
      rdy_prev_r <= 1'b1;
    end else begin
      wr_prev_r <= wr_s;
      rdy_prev_r <= ready_busy;
    end
  end

  // Option register; its soft reset bit survives the reset it causes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      option_r <= CACR_OPT_RESET;
    end else if (cfg_wr && addr[2:1] == CACR_OFS_OPTION[2:1]) begin
      option_r <= wdat;
    end else if (option_r[CACR_OPT_SRST]) begin
      option_r <= {1'b1, 7'h00};
    end
  end

  assign card_reset = option_r[CACR_OPT_SRST];
  assign cmd_hard_reset = option_r[CACR_OPT_SRST];
  assign level_irq_mode = option_r[CACR_OPT_LEVEL];
  assign config_index = option_r[5:0];
  assign io_any_mode = (config_index == CACR_IDX_IO_ANY);
  assign io_primary_mode = (config_index == CACR_IDX_IO_PRI);
  assign io_secondary_mode = (config_index == CACR_IDX_IO_SEC);

  // Status register host bits; soft reset clears them like a hardware reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      change_signal_enable_r <= 1'b0;
      eight_r <= 1'b0;
      pwrdn_r <= 1'b0;
    end else if (card_reset) begin
      change_signal_enable_r <= 1'b0;
      eight_r <= 1'b0;
      pwrdn_r <= 1'b0;
    end else if (cfg_wr && addr[2:1] == CACR_OFS_STATUS[2:1]) begin
      change_signal_enable_r <= wdat[CACR_STS_CHANGE_SIGNAL_ENABLE];
      eight_r <= wdat[CACR_STS_EIGHT];
      pwrdn_r <= wdat[CACR_STS_PWRDN];
    end
  end

  // Changed bits: a ready toggle sets its bit, a masked write sets or clears either bit; set wins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_chg_r <= 1'b0;
      wp_chg_r <= 1'b0;
    end else if (card_reset) begin
      rdy_chg_r <= 1'b0;
      wp_chg_r <= 1'b0;
    end else begin
      if (ready_busy != rdy_prev_r) begin
        rdy_chg_r <= 1'b1;
      end else if (cfg_wr && addr[2:1] == CACR_OFS_PINREP[2:1] && wdat[CACR_PIN_RDYMASK]) begin
        rdy_chg_r <= wdat[CACR_PIN_RDYCHG];
      end
      if (cfg_wr && addr[2:1] == CACR_OFS_PINREP[2:1] && wdat[CACR_PIN_WPMASK]) begin
        wp_chg_r <= wdat[CACR_PIN_WPCHG];
      end
    end
  end

  // Power state: a request change or idle/command drives the target; busy while settling.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      target_lp_r <= 1'b0;
      low_power_r <= 1'b0;
      settle_r <= 16'h0000;
    end else begin
      if (cfg_wr && addr[2:1] == CACR_OFS_STATUS[2:1]
          && wdat[CACR_STS_PWRDN] != pwrdn_r) begin
        target_lp_r <= wdat[CACR_STS_PWRDN];
        settle_r <= 16'(SETTLE_CYC);
      end else if (command_arrived && target_lp_r) begin
        target_lp_r <= 1'b0;
        settle_r <= 16'(SETTLE_CYC);
      end else if (card_idle && !target_lp_r && settle_r == 16'h0000) begin
        target_lp_r <= 1'b1;
      end else if (settle_r != 16'h0000) begin
        settle_r <= settle_r - 16'h0001;
      end
      if (settle_r == 16'h0001) begin
        low_power_r <= target_lp_r;
      end else if (settle_r == 16'h0000) begin
        low_power_r <= target_lp_r;
      end
    end
  end

  assign low_power = low_power_r;
  // The settle window overrides the core's ready so the host waits the change out.
  assign ready_busy = internal_ready && (settle_r == 16'h0000) && !card_reset;

  // Status change pin only acts while the configuration index is not the memory index 0.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_change_out_n <= 1'b1;
    end else begin
      status_change_out_n <= !((config_index != CACR_IDX_MEMORY) && change_signal_enable_r && changed);
    end
  end

  // Read mux; undecoded configuration slots answer zero.
  always_comb begin
    rd_byte = 8'h00;
    if (attr_dec && !addr[9]) begin
      rd_byte = table_rd_data;
    end else if (cfg_dec) begin
      case (addr[2:1])
        CACR_OFS_OPTION[2:1]: rd_byte = option_r;
        CACR_OFS_STATUS[2:1]: begin
          rd_byte[CACR_STS_CHANGED] = changed;
          rd_byte[CACR_STS_CHANGE_SIGNAL_ENABLE] = change_signal_enable_r;
          rd_byte[CACR_STS_EIGHT] = eight_r;
          rd_byte[CACR_STS_PWRDN] = pwrdn_r;
          rd_byte[CACR_STS_INT] = internal_irq && !irq_disable_ctl;
        end
        CACR_OFS_PINREP[2:1]: begin
          rd_byte = CACR_PIN_FIXED;
          rd_byte[CACR_PIN_RDYCHG] = rdy_chg_r;
          rd_byte[CACR_PIN_WPCHG] = wp_chg_r;
          rd_byte[CACR_PIN_RDYMASK] = ready_busy;
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Data lanes are registered; attribute reads never use the upper lanes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= 16'h0000;
      data_lo_oe_n <= 1'b1;
      data_hi_oe_n <= 1'b1;
    end else begin
      data_lo_oe_n <= 1'b1;
      data_hi_oe_n <= 1'b1;
      if (rd_s && !wr_s) begin
        case (space)
          CACR_SP_ATTR: begin
            data_out <= {8'h00, rd_byte};
            data_lo_oe_n <= 1'b0;
          end
          CACR_SP_COMMON: begin
            data_out <= {common_rd_data_hi, common_rd_data};
            data_lo_oe_n <= !lbs_s;
            data_hi_oe_n <= !hbs_s;
          end
          default: data_out <= data_out;
        endcase
      end
    end
  end

  // Common reads present the same stored byte on both lanes.
  assign common_rd_data_hi = common_rd_data;
  assign common_rd_data = table_rd_data;
  assign common_rd_active = (space == CACR_SP_COMMON) && rd_s;
  assign common_lanes = {hbs_s, lbs_s};

  // Common writes; a single high select carries its byte on the upper lanes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      common_wr_data <= 16'h0000;
      common_wr_pulse <= 1'b0;
    end else begin
      common_wr_pulse <= wr_edge && (space == CACR_SP_COMMON);
      if (wr_edge && space == CACR_SP_COMMON) begin
        common_wr_data <= data_in;
      end
    end
  end

  // Attribute read on high lanes never happens.
  a_attr_lanes: assert property (@(posedge clk) disable iff (!arst_n)
    $past(space) == CACR_SP_ATTR |-> data_hi_oe_n)
    else $error("upper lanes driven during attribute access");
  a_standby_hiz: assert property (@(posedge clk) disable iff (!arst_n)
    (!lbs_s && !hbs_s) |=> (data_lo_oe_n && data_hi_oe_n))
    else $error("lanes driven in standby");
  a_odd_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_edge && attr_s && addr[0]) |=> $stable(option_r) || $past(option_r[7]))
    else $error("odd attribute write changed option");
  a_table_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_edge && attr_s && !addr[9] && !option_r[7]) |=> $stable(option_r))
    else $error("table write changed option");
  a_srst_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (option_r[7] && !cfg_wr) |=> option_r[7] && card_reset)
    else $error("soft reset bit cleared itself");
  a_status_change_out_n_pin: assert property (@(posedge clk) disable iff (!arst_n)
    !change_signal_enable_r |=> status_change_out_n)
    else $error("status change pin low while disabled");
  a_pwr_busy: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_wr && addr[2:1] == 2'h1 && wdat[2] != pwrdn_r && !card_reset) |=> !ready_busy[*2])
    else $error("ready during power transition");
  a_rdy_toggle: assert property (@(posedge clk) disable iff (!arst_n)
    (ready_busy != rdy_prev_r && !card_reset) |=> rdy_chg_r)
    else $error("ready change not caught");
endmodule : cacr_regs

// >>> verif/cacr_host.sv
// Host socket controller model that runs card bus cycles for the bench.
`timescale 1ns/100ps
module cacr_host (
  input wire logic clk,
  output logic low_byte_select_n,
  output logic high_byte_select_n,
  output logic attr_space_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [10:0] addr,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_lo_oe_n,
  input wire logic data_hi_oe_n
);
  // The bus idles deselected with both strobes inactive.
  initial begin
    {low_byte_select_n, high_byte_select_n, attr_space_select_n} = 3'b111;
    {read_strobe_n, write_strobe_n} = 2'b11;
    addr = 11'h000;
    data_in = 16'h0000;
  end

  // One cycle: strobe held for five edges so the two sync flops and the register stage settle.
  task automatic cycle(input logic rd, input logic attr_n, input logic [1:0] sel_n,
                       input logic [10:0] a, input logic [15:0] wd, output logic [17:0] ans);
    @(posedge clk);
    attr_space_select_n <= attr_n;
    {high_byte_select_n, low_byte_select_n} <= sel_n;
    addr <= a;
    data_in <= rd ? ~wd : wd;
    read_strobe_n <= !rd;
    write_strobe_n <= rd;
    repeat (5) @(posedge clk);
    ans = {data_hi_oe_n, data_lo_oe_n, data_out};
    // Strobes drop first; address and selects stay until the release has crossed the sync.
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    {high_byte_select_n, low_byte_select_n} <= 2'b11;
    data_in <= ~data_in;
    addr <= ~a;
  endtask : cycle
endmodule : cacr_host

// >>> verif/testbench.sv
// Self-checking bench for the card space decoder and configuration registers.
`timescale 1ns/100ps
module testbench;
  logic clk, arst_n, low_byte_select_n, high_byte_select_n, attr_space_select_n;
  logic read_strobe_n, write_strobe_n, data_lo_oe_n, data_hi_oe_n, common_wr_pulse;
  logic common_rd_active, internal_ready, internal_irq, irq_disable_ctl, card_idle;
  logic command_arrived, card_reset, cmd_hard_reset, level_irq_mode, io_any_mode;
  logic io_primary_mode, io_secondary_mode, status_change_out_n, ready_busy, low_power;
  logic [10:0] addr;
  logic [15:0] data_in, data_out, common_wr_data;
  logic [7:0] common_rd_data, table_rd_addr, table_rd_data;
  logic [1:0] common_lanes;
  logic [5:0] config_index;
  logic [17:0] ans;
  int fails = 0;
  int checks_done = 0;
  int busy_cnt = 0;
  int pulse_cnt = 0;
  int act_cnt = 0;
  int mark;
  wire [3:0] modes = {level_irq_mode, io_any_mode, io_primary_mode, io_secondary_mode};

  cacr_regs #(.SETTLE_CYC(2)) u_cacr_regs (
    .clk(clk),
    .arst_n(arst_n),
    .low_byte_select_n(low_byte_select_n),
    .high_byte_select_n(high_byte_select_n),
    .attr_space_select_n(attr_space_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr(addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_lo_oe_n(data_lo_oe_n),
    .data_hi_oe_n(data_hi_oe_n),
    .common_rd_data(common_rd_data),
    .common_wr_data(common_wr_data),
    .common_wr_pulse(common_wr_pulse),
    .common_rd_active(common_rd_active),
    .common_lanes(common_lanes),
    .table_rd_addr(table_rd_addr),
    .table_rd_data(table_rd_data),
    .internal_ready(internal_ready),
    .internal_irq(internal_irq),
    .irq_disable_ctl(irq_disable_ctl),
    .card_idle(card_idle),
    .command_arrived(command_arrived),
    .card_reset(card_reset),
    .cmd_hard_reset(cmd_hard_reset),
    .level_irq_mode(level_irq_mode),
    .config_index(config_index),
    .io_any_mode(io_any_mode),
    .io_primary_mode(io_primary_mode),
    .io_secondary_mode(io_secondary_mode),
    .status_change_out_n(status_change_out_n),
    .ready_busy(ready_busy),
    .low_power(low_power)
  );
  cacr_host u_cacr_host (
    .clk(clk),
    .low_byte_select_n(low_byte_select_n),
    .high_byte_select_n(high_byte_select_n),
    .attr_space_select_n(attr_space_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr(addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_lo_oe_n(data_lo_oe_n),
    .data_hi_oe_n(data_hi_oe_n)
  );

  // The table contents are a simple function of the address so every read is predictable.
  assign table_rd_data = table_rd_addr ^ 8'h5a;

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Busy cycles, write pulses and read-active cycles are counted as they happen, one per clock.
  always @(posedge clk) begin
    if (ready_busy === 1'b0) busy_cnt <= busy_cnt + 1;
    if (common_wr_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
    if (common_rd_active === 1'b1) act_cnt <= act_cnt + 1;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp, input string w);
    chk({15'h0, got}, {15'h0, exp}, w);
  endtask : chk1

  task automatic cyc(input logic r, input logic at, input logic [1:0] s, input logic [10:0] a,
                     input logic [15:0] wd);
    u_cacr_host.cycle(r, at, s, a, wd, ans);
  endtask : cyc

  // Byte writes go to even attribute addresses on the low lane only.
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    cyc(1'b0, 1'b0, 2'b10, a, {8'h00, d});
  endtask : wr

  // Byte reads expect the low lane driven and the high lane released.
  task automatic rd(input logic [10:0] a, input logic [7:0] e, input string w,
                    input logic [7:0] m = 8'hff);
    cyc(1'b1, 1'b0, 2'b10, a, 16'h0000);
    chk({8'h00, ans[7:0] & m}, {8'h00, e & m}, w);
    chk({14'h0, ans[17:16]}, 16'h0002, w);
  endtask : rd

  // Hangs are cut short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    {arst_n, internal_irq, irq_disable_ctl, card_idle, command_arrived} = 5'b0;
    internal_ready = 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(11'h200, 8'h00, "opt rst");
    rd(11'h202, 8'h00, "sts rst");
    for (int i = 0; i < 4; i++) begin
      wr(11'h200, 8'h40 | 8'(i));
      rd(11'h200, 8'h40 | 8'(i), "opt");
      chk({12'h0, modes}, (i == 0) ? 16'h8 : 16'h8 | (16'h8 >> i), "mode");
    end
    cyc(1'b0, 1'b0, 2'b10, 11'h201, 16'h00ff);
    cyc(1'b0, 1'b0, 2'b01, 11'h200, 16'hffff);
    cyc(1'b0, 1'b0, 2'b10, 11'h000, 16'h00ff);
    rd(11'h200, 8'h43, "refused");
    cyc(1'b1, 1'b0, 2'b10, 11'h201, 16'h0000);
    chk({14'h0, ans[17:16]}, 16'h3, "odd rd");
    cyc(1'b1, 1'b0, 2'b11, 11'h200, 16'h0000);
    chk({14'h0, ans[17:16]}, 16'h3, "standby");
    cyc(1'b1, 1'b0, 2'b00, 11'h200, 16'h0000);
    chk({8'h0, ans[7:0]}, 16'h43, "word attr");
    rd(11'h00c, 8'h06 ^ 8'h5a, "table");
    for (int s = 1; s < 4; s++) begin
      mark = act_cnt;
      cyc(1'b1, 1'b1, ~2'(s), 11'h010, 16'h0000);
      chk({14'h0, ans[17:16]}, {14'h0, ~2'(s)}, "lanes");
      chk(ans[15:0], 16'h5252, "common rd");
      chk({14'h0, common_lanes}, {14'h0, 2'(s)}, "sel lanes");
      chk1(act_cnt > mark, 1'b1, "rd active");
    end
    mark = pulse_cnt;
    cyc(1'b0, 1'b1, 2'b00, 11'h010, 16'ha55a);
    chk(common_wr_data, 16'ha55a, "common wr");
    chk1(pulse_cnt == mark + 1, 1'b1, "wr pulse");
    mark = busy_cnt;
    wr(11'h202, 8'he4);
    chk1(busy_cnt > mark, 1'b1, "busy");
    chk1(low_power, 1'b1, "low power");
    wr(11'h204, 8'h03);
    rd(11'h202, 8'h64, "sts");
    chk1(status_change_out_n, 1'b1, "no change");
    internal_ready <= 1'b0;
    rd(11'h204, 8'h20, "rdy chg", 8'h20);
    rd(11'h202, 8'he4, "changed");
    chk1(status_change_out_n, 1'b0, "chg out");
    internal_irq <= 1'b1;
    rd(11'h202, 8'he6, "irq");
    irq_disable_ctl <= 1'b1;
    rd(11'h202, 8'he4, "irq off");
    wr(11'h202, 8'h24);
    chk1(status_change_out_n, 1'b1, "sig off");
    internal_ready <= 1'b1;
    wr(11'h204, 8'h02);
    wr(11'h204, 8'h20);
    rd(11'h202, 8'h24, "cleared");
    mark = busy_cnt;
    wr(11'h202, 8'h20);
    chk1(busy_cnt > mark, 1'b1, "busy up");
    chk1(low_power, 1'b0, "active");
    card_idle <= 1'b1;
    repeat (6) @(posedge clk);
    chk1(low_power, 1'b1, "idle");
    card_idle <= 1'b0;
    command_arrived <= 1'b1;
    @(posedge clk);
    command_arrived <= 1'b0;
    repeat (6) @(posedge clk);
    chk1(low_power, 1'b0, "wake");
    wr(11'h200, 8'h80);
    chk({14'h0, card_reset, cmd_hard_reset}, 16'h3, "soft rst");
    rd(11'h200, 8'h80, "srst kept");
    rd(11'h202, 8'h00, "sts clr");
    wr(11'h200, 8'h00);
    chk({9'h0, card_reset, config_index}, 16'h0, "unconfigured");
    rd(11'h206, 8'h00, "socket");
    rd(11'h208, 8'h00, "reserved");
    wr(11'h200, 8'h41);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(11'h200, 8'h00, "re-reset");
    complete_run();
  end
endmodule : testbench
